/* pkg/irq_pkg.sv */
// Package: constants and carriers for the vectored interrupt logic
package irq_pkg;
    localparam logic [12:0] VEC_EXT     = 13'h0003;
    localparam logic [12:0] VEC_SERIAL  = 13'h0005;
    localparam logic [12:0] VEC_TIMER   = 13'h0007;
    localparam logic [1:0]  PC_BANK_ZERO = 2'h0;
    localparam int          PSW_RBS_BIT = 4;
    localparam int          PSW_AC_BIT  = 6;
    localparam int          PSW_CY_BIT  = 7;
    localparam int          LOW_NS      = 32;   // Input low above 4 periods at 8 ns
    localparam int          HIGH_NS     = 56;   // Input high at least 7 periods at 8 ns
    localparam int          CLK_NS      = 8;
    localparam int          LOW_CYCLES  = (LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int          HIGH_CYCLES = (HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0]  FILT_RESET  = 4'h0;
    localparam logic [7:0]  COUNTER_ALL_ONES = 8'hFF;

    // Instruction strobes from the core sequencer
    typedef struct packed {
        logic boundary;
        logic ext_irq_enable_instr;
        logic ext_irq_disable_instr;
        logic serial_irq_enable_instr;
        logic serial_irq_disable_instr;
        logic counter_irq_enable_instr;
        logic counter_irq_disable_instr;
        logic return_restore_instr;
        logic jump_if_tflag_set;
        logic jump_if_tflag_clear;
    } core_cmd_t;

    // Vectored call toward the core
    typedef struct packed {
        logic        take;
        logic [12:0] vector;
        logic [12:0] push_pc;
        logic [2:0]  push_psw;
    } call_t;
endpackage

/* verilog/sync_two.sv */
// Two-stage synchroniser for one pin
`timescale 1ns/1ps
`default_nettype none
module sync_two (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level
);
    logic stage1;
    logic next_stage1;
    logic next_level;

    // Next values
    always_comb begin
        next_stage1 = pin;
        next_level  = stage1;
    end

    // Register stages
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage1 <= 1'b0;
            level  <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            level  <= next_level;
        end
    end
endmodule
`default_nettype wire

/* verilog/edge_filter.sv */
// Digital filter and rising edge detector for one input
`timescale 1ns/1ps
`default_nettype none
module edge_filter #(
    parameter int LOW_MIN  = 4,
    parameter int HIGH_MIN = 7
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic level,
    output logic      rise
);
    logic [3:0] count;
    logic       armed;
    logic [3:0] next_count;
    logic       next_armed;

    // Count stable level; arm after low, fire after high
    always_comb begin
        next_count = count;
        next_armed = armed;
        rise       = 1'b0;
        if (!level) begin
            next_count = (armed || count == 4'(LOW_MIN)) ? count : count + 4'h1;
            if (count == 4'(LOW_MIN))
                next_armed = 1'b1;
            if (armed)
                next_count = irq_pkg::FILT_RESET;
        end else if (armed) begin
            next_count = count + 4'h1;
            if (count == 4'(HIGH_MIN - 1)) begin
                rise       = 1'b1;
                next_armed = 1'b0;
                next_count = irq_pkg::FILT_RESET;
            end
        end else begin
            next_count = irq_pkg::FILT_RESET;
        end
    end

    // Register filter state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count <= irq_pkg::FILT_RESET;
            armed <= 1'b0;
        end else begin
            count <= next_count;
            armed <= next_armed;
        end
    end
endmodule
`default_nettype wire

/* verilog/vectored_irq.sv */
// Single-level vectored interrupt logic
// How it works
// - Enabled external rising edge calls vector 3 after current instruction.
// - Enabled serial request calls vector 5.
// - Counter overflow calls vector 7 only while timer interrupt enabled.
// - Call pushes full program counter and status bits 4, 6, 7.
// - One level: later requests latch, serviced only after return-restore.
// - After return-restore execution resumes in main program first.
// - Priority: external, then serial, then timer.
// - Counter preset to all ones plus enable gives edge call at vector 7.
// - External disable clears edge latch and external flag.
// - Timer overflow flag cleared only by flag jumps or reset.
// - Timer interrupt flag set on overflow only while enabled.
// - Idle exits on a request from any enabled source.
// - Serial enable and disable instructions steer serial interrupt logic.
// - Disabled serial still shows pending bit; no vectored call.
// - Every external rising edge is captured whatever the enable, except one in the same cycle as an external disable instruction.
// - Pending-not bit reads zero while serial request pending.
// - Reset disables external, timer and serial interrupts.
// - Top two program counter bits forced zero inside routine.
`timescale 1ns/1ps
`default_nettype none
module vectored_irq (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              ext_irq_input,
    input  wire irq_pkg::core_cmd_t cmd,
    input  wire logic              serial_pending,
    input  wire logic              counter_overflow,
    input  wire logic              idle,
    input  wire logic [12:0]       pc,
    input  wire logic [7:0]        program_status_word,
    output var irq_pkg::call_t     call,
    output logic                   pending_not,
    output logic                   timer_overflow_flag,
    output logic                   jump_tflag_taken,
    output logic                   in_progress,
    output logic [1:0]             pc_high_mask,
    output logic                   idle_exit
);
    // ****************************************
    // Input capture
    // ****************************************
    logic ext_level;
    logic ext_rise;

    sync_two u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (ext_irq_input),
        .level   (ext_level)
    );

    edge_filter #(
        .LOW_MIN  (irq_pkg::LOW_CYCLES),
        .HIGH_MIN (irq_pkg::HIGH_CYCLES)
    ) u_filt (
        .clk_sys (clk_sys),
        .rst     (rst),
        .level   (ext_level),
        .rise    (ext_rise)
    );

    // ****************************************
    // Enables and flags
    // ****************************************
    logic ext_en;
    logic serial_en;
    logic timer_en;
    logic ext_latch;
    logic timer_irq_flag;
    logic next_ext_en;
    logic next_serial_en;
    logic next_timer_en;
    logic next_ext_latch;
    logic next_timer_irq_flag;
    logic next_tflag;
    logic next_in_progress;
    logic take_ext;
    logic take_serial;
    logic take_timer;
    logic any_take;

    // Arbitration at instruction boundaries
    always_comb begin
        any_take    = cmd.boundary && !in_progress && !cmd.return_restore_instr;
        take_ext    = any_take && ext_en && ext_latch && !cmd.ext_irq_disable_instr;
        take_serial = any_take && !take_ext && serial_en && serial_pending;
        take_timer  = any_take && !take_ext && !take_serial && timer_irq_flag;
    end

    // Next flag values
    always_comb begin
        next_ext_en         = ext_en;
        next_serial_en      = serial_en;
        next_timer_en       = timer_en;
        next_ext_latch      = ext_latch;
        next_timer_irq_flag = timer_irq_flag;
        next_tflag          = timer_overflow_flag;
        next_in_progress    = in_progress;
        if (cmd.ext_irq_enable_instr)
            next_ext_en = 1'b1;
        if (cmd.ext_irq_disable_instr)
            next_ext_en = 1'b0;
        if (cmd.serial_irq_enable_instr)
            next_serial_en = 1'b1;
        if (cmd.serial_irq_disable_instr)
            next_serial_en = 1'b0;
        if (cmd.counter_irq_enable_instr)
            next_timer_en = 1'b1;
        if (cmd.counter_irq_disable_instr)
            next_timer_en = 1'b0;
        // Accepted source latch cleared on call
        if (take_ext)
            next_ext_latch = 1'b0;
        if (take_timer)
            next_timer_irq_flag = 1'b0;
        // Disable wipes pending external request
        if (cmd.ext_irq_disable_instr)
            next_ext_latch = 1'b0;
        // Edge capture wins over call clear, not over disable
        if (ext_rise && !cmd.ext_irq_disable_instr)
            next_ext_latch = 1'b1;
        if (!timer_en)
            next_timer_irq_flag = 1'b0;
        if (counter_overflow && timer_en)
            next_timer_irq_flag = 1'b1;
        // Overflow flag: only jumps clear it, set wins
        if (cmd.jump_if_tflag_set || cmd.jump_if_tflag_clear)
            next_tflag = 1'b0;
        if (counter_overflow)
            next_tflag = 1'b1;
        if (cmd.return_restore_instr)
            next_in_progress = 1'b0;
        if (take_ext || take_serial || take_timer)
            next_in_progress = 1'b1;
    end

    // Register flags
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_en              <= 1'b0;
            serial_en           <= 1'b0;
            timer_en            <= 1'b0;
            ext_latch           <= 1'b0;
            timer_irq_flag      <= 1'b0;
            timer_overflow_flag <= 1'b0;
            in_progress         <= 1'b0;
        end else begin
            ext_en              <= next_ext_en;
            serial_en           <= next_serial_en;
            timer_en            <= next_timer_en;
            ext_latch           <= next_ext_latch;
            timer_irq_flag      <= next_timer_irq_flag;
            timer_overflow_flag <= next_tflag;
            in_progress         <= next_in_progress;
        end
    end

    // ****************************************
    // Call and status outputs
    // ****************************************
    irq_pkg::call_t next_call;
    logic           next_jump_taken;
    logic           next_idle_exit;

    // Build the call record
    always_comb begin
        next_call          = '0;
        next_call.take     = take_ext || take_serial || take_timer;
        next_call.push_pc  = pc;
        next_call.push_psw = {program_status_word[irq_pkg::PSW_CY_BIT],
                              program_status_word[irq_pkg::PSW_AC_BIT],
                              program_status_word[irq_pkg::PSW_RBS_BIT]};
        if (take_ext)
            next_call.vector = irq_pkg::VEC_EXT;
        else if (take_serial)
            next_call.vector = irq_pkg::VEC_SERIAL;
        else if (take_timer)
            next_call.vector = irq_pkg::VEC_TIMER;
        next_jump_taken = cmd.jump_if_tflag_set ? timer_overflow_flag
                        : (cmd.jump_if_tflag_clear && !timer_overflow_flag);
        next_idle_exit  = idle && ((ext_en && ext_latch) || (serial_en && serial_pending)
                        || timer_irq_flag);
    end

    // Register outputs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            call             <= '0;
            jump_tflag_taken <= 1'b0;
            idle_exit        <= 1'b0;
        end else begin
            call             <= next_call;
            jump_tflag_taken <= next_jump_taken;
            idle_exit        <= next_idle_exit;
        end
    end

    // Status bit and bank forcing
    assign pending_not  = !serial_pending;
    assign pc_high_mask = in_progress ? irq_pkg::PC_BANK_ZERO : 2'h3;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_accept;
        call.take;
    endsequence

    sequence s_busy_until_return;
        in_progress [*2];
    endsequence

    a_ext_vector: assert property (@(posedge clk_sys) disable iff (rst)
        take_ext |=> call.take && call.vector == 13'h0003)
        else $error("external call without vector 3");

    a_serial_vector: assert property (@(posedge clk_sys) disable iff (rst)
        take_serial |=> call.vector == 13'h0005)
        else $error("serial call without vector 5");

    a_timer_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (counter_overflow && !timer_en) |=> !timer_irq_flag)
        else $error("timer flag set while disabled");

    a_single_level: assert property (@(posedge clk_sys) disable iff (rst)
        in_progress && !cmd.return_restore_instr |=> !call.take)
        else $error("call taken while routine in progress");

    a_resume_main: assert property (@(posedge clk_sys) disable iff (rst)
        cmd.return_restore_instr |=> !call.take)
        else $error("call straight after return");

    a_priority_order: assert property (@(posedge clk_sys) disable iff (rst)
        (take_serial || take_timer) |-> !(ext_en && ext_latch && !cmd.ext_irq_disable_instr))
        else $error("lower source beat external");

    a_disable_clears: assert property (@(posedge clk_sys) disable iff (rst)
        cmd.ext_irq_disable_instr |=> !ext_latch)
        else $error("external latch survives disable");

    a_tflag_hold: assert property (@(posedge clk_sys) disable iff (rst)
        timer_overflow_flag && !cmd.jump_if_tflag_set && !cmd.jump_if_tflag_clear
        |=> timer_overflow_flag)
        else $error("overflow flag lost");

    // Overflow always sets the flag, even against a jump clear
    a_overflow_sets: assert property (@(posedge clk_sys) disable iff (rst)
        counter_overflow |=> timer_overflow_flag)
        else $error("overflow did not set flag");

    a_progress_flag: assert property (@(posedge clk_sys) disable iff (rst)
        s_accept ##0 !cmd.return_restore_instr |-> s_busy_until_return)
        else $error("in progress flag not set on call");

    a_bank_zero: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(in_progress) |-> pc_high_mask == 2'h0)
        else $error("bank not forced in routine");
endmodule
`default_nettype wire

/* verification/event_counter_model.sv */
// Partner model: event counter that feeds the overflow strobe
`timescale 1ns/1ps
`default_nettype none
module event_counter_model (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       preset,
    input  wire logic [7:0] preset_value,
    input  wire logic       event_count_input,
    output logic            counter_overflow
);
    logic [7:0] count;
    logic       last_in;

    // Count rising edges, pulse once on the wrap from all ones
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count            <= 8'h00;
            last_in          <= 1'b0;
            counter_overflow <= 1'b0;
        end else begin
            last_in          <= event_count_input;
            counter_overflow <= 1'b0;
            if (preset) begin
                count <= preset_value;
            end else if (event_count_input && !last_in) begin
                count            <= count + 8'h01;
                counter_overflow <= (count == 8'hFF);
            end
        end
    end
endmodule
`default_nettype wire

/* verification/vectored_irq_tb_top.sv */
// Testbench: directed scenarios for the vectored interrupt logic
`timescale 1ns/1ps
`default_nettype none
module vectored_irq_tb_top;
    // ******************************************
    // Stimulus, model and design
    // ******************************************
    localparam int BND = 0, EXT_EN = 1, EXT_DIS = 2, SER_EN = 3, SER_DIS = 4;
    localparam int CNT_EN = 5, CNT_DIS = 6, RR = 7, JSET = 8, JCLR = 9;
    logic               clk_sys, rst, ext_irq_input, serial_pending, idle;
    logic               counter_overflow, preset, event_in;
    logic [12:0]        pc;
    logic [7:0]         program_status_word;
    irq_pkg::core_cmd_t cmd;
    irq_pkg::call_t     call;
    irq_pkg::call_t     seen_call;
    logic               seen_jump;
    logic               pending_not, timer_overflow_flag, jump_tflag_taken;
    logic               in_progress, idle_exit;
    logic [1:0]         pc_high_mask;
    int                 comparisons, miscompares;

    event_counter_model event_counter_model_i (
        .clk_sys(clk_sys), .rst(rst), .preset(preset), .preset_value(8'hFF),
        .event_count_input(event_in), .counter_overflow(counter_overflow));
    vectored_irq vectored_irq_i (
        .clk_sys(clk_sys), .rst(rst), .ext_irq_input(ext_irq_input), .cmd(cmd),
        .serial_pending(serial_pending), .counter_overflow(counter_overflow),
        .idle(idle), .pc(pc), .program_status_word(program_status_word),
        .call(call), .pending_not(pending_not),
        .timer_overflow_flag(timer_overflow_flag), .jump_tflag_taken(jump_tflag_taken),
        .in_progress(in_progress), .pc_high_mask(pc_high_mask), .idle_exit(idle_exit));

    // Clock generation
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task report_and_stop;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One-cycle strobe, one or two instructions; captures pulses, then one idle cycle
    task issue(input int k, input int k2 = -1);
        logic [9:0] v;
        v = 10'h200 >> k;
        if (k2 >= 0) begin
            v = v | (10'h200 >> k2);
        end
        cmd = irq_pkg::core_cmd_t'(v);
        @(posedge clk_sys);
        #1 cmd = '0;
        seen_call = call;
        seen_jump = jump_tflag_taken;
        @(posedge clk_sys);
        #1;
    endtask

    // Boundary, then judge the call that stood in the next cycle
    task bnd(input logic take, input logic [12:0] vec, input int k2 = -1);
        issue(BND, k2);
        check(seen_call.take, take);
        if (take) begin
            check(seen_call.vector, vec);
            check(seen_call.push_pc, pc);
            check(seen_call.push_psw, {program_status_word[7:6], program_status_word[4]});
            check(in_progress, 1'b1);
            check(pc_high_mask, 2'h0);
        end
    endtask

    // Low then high long enough for the filter
    task ext_edge;
        ext_irq_input = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1 ext_irq_input = 1'b1;
        repeat (14) @(posedge clk_sys);
        #1;
    endtask

    // Preset counter to all ones, then one event edge wraps it
    task overflow;
        preset = 1'b1;
        @(posedge clk_sys);
        #1 preset = 1'b0;
        event_in = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 event_in = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    // ******************************************
    // Scenarios
    // ******************************************
    task t_reset;
        check(in_progress, 1'b0);
        check(timer_overflow_flag, 1'b0);
        check(pc_high_mask, 2'h3);
        serial_pending = 1'b1;
        bnd(1'b0, 13'h0000);
        serial_pending = 1'b0;
        $display("reset test done");
    endtask

    task t_ext;
        ext_edge;
        issue(EXT_EN);
        bnd(1'b1, irq_pkg::VEC_EXT);
        $display("external test done");
    endtask

    task t_single;
        issue(SER_EN);
        serial_pending = 1'b1;
        bnd(1'b0, 13'h0000);
        bnd(1'b0, 13'h0000, RR);
        check(in_progress, 1'b0);
        bnd(1'b1, irq_pkg::VEC_SERIAL);
        serial_pending = 1'b0;
        issue(RR);
        $display("single level test done");
    endtask

    task t_prio;
        issue(CNT_EN);
        ext_edge;
        serial_pending = 1'b1;
        overflow;
        bnd(1'b1, irq_pkg::VEC_EXT);
        issue(RR);
        bnd(1'b1, irq_pkg::VEC_SERIAL);
        serial_pending = 1'b0;
        issue(RR);
        bnd(1'b1, irq_pkg::VEC_TIMER);
        issue(RR);
        bnd(1'b0, 13'h0000);
        $display("priority test done");
    endtask

    task t_clear;
        ext_edge;
        issue(EXT_DIS);
        issue(EXT_EN);
        bnd(1'b0, 13'h0000);
        issue(EXT_DIS);
        $display("disable test done");
    endtask

    task t_timer;
        issue(CNT_DIS);
        issue(JSET);
        check(seen_jump, 1'b1);
        overflow;
        check(timer_overflow_flag, 1'b1);
        bnd(1'b0, 13'h0000);
        issue(RR);
        check(timer_overflow_flag, 1'b1);
        issue(JSET);
        check(seen_jump, 1'b1);
        check(timer_overflow_flag, 1'b0);
        issue(JCLR);
        check(seen_jump, 1'b1);
        check(timer_overflow_flag, 1'b0);
        $display("timer flag test done");
    endtask

    task t_serial_off;
        issue(SER_DIS);
        serial_pending = 1'b1;
        #1 check(pending_not, 1'b0);
        bnd(1'b0, 13'h0000);
        serial_pending = 1'b0;
        #1 check(pending_not, 1'b1);
        $display("serial disabled test done");
    endtask

    task t_idle;
        int n;
        issue(SER_EN);
        idle = 1'b1;
        serial_pending = 1'b1;
        for (n = 0; n < 4 && idle_exit !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        check(idle_exit, 1'b1);
        if (idle_exit !== 1'b1) begin
            report_and_stop;
        end
        idle = 1'b0;
        serial_pending = 1'b0;
        $display("idle test done");
    endtask

    // Main sequence
    initial begin
        comparisons = 0;
        miscompares = 0;
        rst = 1'b1;
        ext_irq_input = 1'b0;
        cmd = '0;
        serial_pending = 1'b0;
        idle = 1'b0;
        pc = 13'h1A5C;
        program_status_word = 8'h90;
        preset = 1'b0;
        event_in = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1 rst = 1'b0;
        t_reset;
        t_ext;
        t_single;
        t_prio;
        t_clear;
        t_timer;
        t_serial_off;
        t_idle;
        report_and_stop;
    end
endmodule
`default_nettype wire
